// File: core/btr_proc_end.sv
// module: processor end of the address and data tenures
//
// Operation
// RL1 - hold address tenure until acknowledge arrives
// RL2 - address tenure lasts at least three clocks
// RL3 - snoop drive: assert, float, precharge, float
// RL4 - system acknowledges exactly one clock per tenure
// RL5 - config bit disables precharge, float two
// RL6 - retry drops request next clock, then re-request
// RL7 - arbiter grants retrying snooper next
// RL8 - sample retry only clock after acknowledge
// RL9 - snooper may assert retry before acknowledge
// RL10 - no transfer acknowledge before address acknowledge
// RL11 - retry while busy aborts data tenure
// RL12 - grant in retry window with retry ignored
// RL13 - decode four snoop response combinations
// RL14 - fill marks exclusive or shared by response
// RL15 - invalidate type forces exclusive marking
// RL16 - shared is don't-care when retry asserted
// RL17 - arbiter qualifies start, no address-only grant
// RL18 - grant qualified by busy, data, address retry
// RL19 - busy follows qualified grant unless retried
// RL20 - earlier pipelined data still completes
// RL21 - busy per transaction, drop after final ack
// RL22 - share busy only with master hand-off
// RL23 - sample inputs and update on rising edge
module btr_proc_end
  import btr_pkg::*;
(
  btr_bus_if.proc    bus,
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  input  wire logic  req_valid,
  input  wire logic  req_addr_only,
  input  wire logic  req_burst,
  input  wire logic  req_invalidate,
  output logic       req_ready,
  output logic       tenure_done,
  output logic       tenure_retried,
  output btr_coh_t   fill_state,
  output btr_snoop_t snoop_decode,
  output logic       data_active
);

  typedef enum logic [2:0] {
    PE_IDLE, PE_REQ, PE_START, PE_ADDR, PE_WINDOW, PE_BACKOFF
  } btr_pe_state_t;

  btr_pe_state_t state_r;
  logic [2:0]    tenure_cnt_r;
  logic          br_r;
  logic          ts_r;
  logic          addr_only_r;
  logic          burst_r;
  logic          inval_r;
  logic          aacked_r;
  logic          data_owed_r;
  logic          dbb_r;
  logic [2:0]    beats_r;
  logic          ready_r;
  logic          done_r;
  logic          retried_r;
  btr_coh_t      fill_r;
  btr_snoop_t    snoop_r;
  logic          in_window;
  logic          retry_seen;
  logic          shared_seen;
  logic          qualified_data_grant;
  logic          last_ack;

  // ----------------------------------------------------------------
  // qualified inputs
  // ----------------------------------------------------------------
  assign in_window   = (state_r == PE_WINDOW);
  assign retry_seen  = in_window && !bus.addr_retry_response;   // [RL8] [RL23]
  assign shared_seen = in_window && !bus.snoop_shared_response; // [RL16]
  assign qualified_data_grant        = bus.data_grant && bus.data_busy && !bus.data_retry
                       && bus.addr_retry_response;             // [RL18]
  assign last_ack    = dbb_r && bus.transfer_ack && (beats_r == 3'h1);

  // ----------------------------------------------------------------
  // address tenure
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= PE_IDLE;
      tenure_cnt_r <= CNT_RST;
      br_r         <= 1'b0;
      ts_r         <= 1'b0;
      aacked_r     <= 1'b0;
      addr_only_r  <= 1'b0;
      burst_r      <= 1'b0;
      inval_r      <= 1'b0;
    end else begin
      ts_r <= 1'b0;
      case (state_r)
        PE_IDLE: begin
          if (req_valid && !data_owed_r) begin
            addr_only_r <= req_addr_only;
            burst_r     <= req_burst;
            inval_r     <= req_invalidate;
            br_r        <= 1'b1;
            state_r     <= PE_REQ;
          end
        end
        PE_REQ: begin
          br_r    <= 1'b0;
          ts_r    <= 1'b1;
          state_r <= PE_START;
        end
        PE_START: begin
          tenure_cnt_r <= 3'h1;
          aacked_r     <= 1'b0;
          state_r      <= PE_ADDR;
        end
        PE_ADDR: begin
          if (tenure_cnt_r < 3'(MIN_ADDR_TENURE_CLKS)) tenure_cnt_r <= tenure_cnt_r + 3'h1;
          if (bus.address_acknowledge) aacked_r <= 1'b1;        // [RL1]
          if ((aacked_r || bus.address_acknowledge)
              && tenure_cnt_r >= 3'(MIN_ADDR_TENURE_CLKS - 1)) state_r <= PE_WINDOW; // [RL2]
        end
        PE_WINDOW: begin
          state_r <= retry_seen ? PE_BACKOFF : PE_IDLE;
        end
        PE_BACKOFF: begin
          br_r    <= 1'b1;                                     // [RL6]
          state_r <= PE_REQ;
        end
        default: state_r <= PE_IDLE;
      endcase
    end
  end
  assign bus.bus_request           = br_r;
  assign bus.transfer_start        = ts_r;
  assign bus.address_only_type_bit = addr_only_r;
  assign bus.burst                 = burst_r;
  assign bus.invalidate_type_bit   = inval_r;

  // ----------------------------------------------------------------
  // data tenure
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_owed_r <= 1'b0;
      dbb_r       <= 1'b0;
      beats_r     <= CNT_RST;
    end else begin
      // each data tenure owed by its start
      if (ts_r && !addr_only_r) data_owed_r <= 1'b1;
      // retry in window drops a held busy at once
      if (dbb_r && retry_seen) begin                           // [RL11]
        dbb_r       <= 1'b0;
        data_owed_r <= 1'b0;
        beats_r     <= CNT_RST;
      end else if (last_ack) begin
        dbb_r       <= 1'b0;                                   // [RL21]
        data_owed_r <= 1'b0;
        beats_r     <= CNT_RST;
      end else if (dbb_r && bus.transfer_ack) begin
        beats_r <= beats_r - 3'h1;
      end else if (!dbb_r && data_owed_r && qualified_data_grant && !retry_seen) begin // [RL12] [RL19] [RL20]
        dbb_r       <= 1'b1;
        beats_r     <= burst_r ? BURST_BEATS_W : SINGLE_BEATS_W;
      end else if (!dbb_r && retry_seen) begin
        data_owed_r <= 1'b0;
      end
    end
  end
  // busy line pulled low while held
  assign bus.data_busy_o  = 1'b0;
  assign bus.data_busy_oe = dbb_r;

  // ----------------------------------------------------------------
  // snoop response decode and fill state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snoop_r   <= BTR_SNP_CLEAN;
      fill_r    <= BTR_COH_INVALID;
      done_r    <= 1'b0;
      retried_r <= 1'b0;
      ready_r   <= 1'b0;
    end else begin
      done_r    <= in_window && !retry_seen;
      retried_r <= retry_seen;
      ready_r   <= (state_r == PE_IDLE) && !data_owed_r;
      if (in_window) begin
        case ({shared_seen, retry_seen})                        // [RL13]
          2'b01:   snoop_r <= BTR_SNP_BUSY_RETRY;
          2'b10:   snoop_r <= BTR_SNP_SHARED_HIT;
          2'b11:   snoop_r <= BTR_SNP_MODIFIED_HIT;
          default: snoop_r <= BTR_SNP_CLEAN;
        endcase
        if (retry_seen) fill_r <= BTR_COH_RETRIED;             // [RL16]
        else if (inval_r) fill_r <= BTR_COH_EXCLUSIVE;         // [RL15]
        else if (shared_seen) fill_r <= BTR_COH_SHARED;        // [RL14]
        else fill_r <= BTR_COH_EXCLUSIVE;                      // [RL14]
      end
    end
  end

  assign req_ready      = ready_r;
  assign tenure_done    = done_r;
  assign tenure_retried = retried_r;
  assign fill_state     = fill_r;
  assign snoop_decode   = snoop_r;
  assign data_active    = dbb_r;

endmodule : btr_proc_end

// File: core/btr_pkg.sv
// package: shared constants and types for the bus tenure and retry arbitration block
package btr_pkg;

  // ----------------------------------------------------------------
  // tenure timing
  // ----------------------------------------------------------------
  localparam int unsigned MIN_ADDR_TENURE_CLKS = 3;
  localparam int unsigned HIZ_RELEASE_CLKS     = 2;
  localparam logic [1:0]  MIN_ADDRESS_ACKNOWLEDGE_DELAY       = 2'h1;
  localparam int unsigned BURST_BEATS          = 4;
  localparam logic [2:0]  BURST_BEATS_W        = 3'h4;
  localparam logic [2:0]  SINGLE_BEATS_W       = 3'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  CNT_RST   = 3'h0;
  localparam logic [1:0]  COH_RST   = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BTR_COH_INVALID,
    BTR_COH_EXCLUSIVE,
    BTR_COH_SHARED,
    BTR_COH_RETRIED
  } btr_coh_t;

  typedef enum logic [1:0] {
    BTR_SNP_CLEAN,
    BTR_SNP_BUSY_RETRY,
    BTR_SNP_SHARED_HIT,
    BTR_SNP_MODIFIED_HIT
  } btr_snoop_t;

endpackage : btr_pkg

// File: core/btr_bus_if.sv
// interface: address and data tenure signals between processor end and system end
interface btr_bus_if;
  logic transfer_start;
  logic invalidate_type_bit;
  logic address_only_type_bit;
  logic burst;
  logic bus_request;
  logic address_acknowledge;
  logic data_grant;
  logic data_retry;
  logic transfer_ack;
  logic data_busy_o;
  logic data_busy_oe;
  logic retry_o;
  logic retry_oe;
  logic shared_o;
  logic shared_oe;
  // wired lines: low when any end drives low, else high (pulled/precharged)
  logic addr_retry_response;
  logic snoop_shared_response;
  logic data_busy;

  assign addr_retry_response   = !(retry_oe && !retry_o);
  assign snoop_shared_response = !(shared_oe && !shared_o);
  assign data_busy             = !(data_busy_oe && !data_busy_o);

  modport proc (
    output transfer_start, invalidate_type_bit, address_only_type_bit, burst, bus_request,
    output data_busy_o, data_busy_oe,
    input  address_acknowledge, data_grant, data_retry, transfer_ack,
    input  addr_retry_response, snoop_shared_response, data_busy
  );
  modport sys (
    input  transfer_start, invalidate_type_bit, address_only_type_bit, burst, bus_request,
    input  data_busy, addr_retry_response,
    output address_acknowledge, data_grant, data_retry, transfer_ack,
    output retry_o, retry_oe, shared_o, shared_oe
  );
endinterface : btr_bus_if

// File: core/btr_snoop_drv.sv
// module: shared snoop line driver with assert, float, precharge, float sequence
module btr_snoop_drv
  import btr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic fire,
  input  wire logic no_precharge,
  output logic      line_o,
  output logic      line_oe
);

  typedef enum logic [2:0] {
    SD_IDLE, SD_ASSERT, SD_FLOAT, SD_PRECHARGE, SD_HIZ
  } btr_sd_state_t;

  btr_sd_state_t state_r;
  logic [2:0]    hiz_cnt_r;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= SD_IDLE;
      hiz_cnt_r <= CNT_RST;
    end else begin
      case (state_r)
        SD_IDLE: begin
          if (fire) state_r <= SD_ASSERT;
        end
        SD_ASSERT: state_r <= SD_FLOAT;                        // [RL3]
        SD_FLOAT: begin
          if (no_precharge) begin                              // [RL5]
            state_r   <= SD_HIZ;
            hiz_cnt_r <= 3'h1;
          end else begin
            state_r <= SD_PRECHARGE;                           // [RL3]
          end
        end
        SD_PRECHARGE: state_r <= SD_IDLE;
        SD_HIZ: begin
          if (hiz_cnt_r >= 3'(HIZ_RELEASE_CLKS)) state_r <= SD_IDLE;
          else hiz_cnt_r <= hiz_cnt_r + 3'h1;
        end
        default: state_r <= SD_IDLE;
      endcase
    end
  end

  // precharge high held for one bus clock, standing in for the double rate period
  assign line_o  = (state_r != SD_ASSERT);
  assign line_oe = (state_r == SD_ASSERT) || (state_r == SD_PRECHARGE);

endmodule : btr_snoop_drv

// File: core/btr_sys_end.sv
// module: system end: arbiter, memory slave and one snooping master
module btr_sys_end
  import btr_pkg::*;
(
  btr_bus_if.sys    bus,
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic snoop_retry_req,
  input  wire logic snoop_shared_req,
  input  wire logic hw_impl_config_reg,
  input  wire logic [1:0] address_acknowledge_delay,
  output logic      snoop_pending
);

  logic [1:0] wait_r;
  logic       addr_open_r;
  logic       address_acknowledge_r;
  logic       data_due_r;
  logic       dgrant_r;
  logic       beats_go_r;
  logic [2:0] beats_r;
  logic       snoop_fire;
  logic       address_acknowledge_due;

  // ----------------------------------------------------------------
  // address acknowledge, one clock per tenure
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_open_r <= 1'b0;
      wait_r      <= 2'h0;
      address_acknowledge_r      <= 1'b0;
    end else begin
      address_acknowledge_r <= 1'b0;
      if (bus.transfer_start) begin
        addr_open_r <= 1'b1;
        wait_r      <= MIN_ADDRESS_ACKNOWLEDGE_DELAY;
      end else if (addr_open_r) begin
        if (wait_r >= address_acknowledge_delay) begin
          address_acknowledge_r      <= 1'b1;                                 // [RL4]
          addr_open_r <= 1'b0;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
  assign bus.address_acknowledge = address_acknowledge_r;
  assign address_acknowledge_due = addr_open_r && !bus.transfer_start && (wait_r >= address_acknowledge_delay);

  // ----------------------------------------------------------------
  // data grant: burst with acknowledge, single in retry window
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_due_r <= 1'b0;
      dgrant_r   <= 1'b0;
    end else begin
      dgrant_r <= 1'b0;
      if (bus.transfer_start && !bus.address_only_type_bit) data_due_r <= 1'b1; // [RL17]
      else if (data_due_r && bus.data_busy && (bus.burst ? address_acknowledge_due : address_acknowledge_r)) begin // [RL10]
        dgrant_r   <= 1'b1;
        data_due_r <= 1'b0;
      end
    end
  end
  assign bus.data_grant = dgrant_r;

  // ----------------------------------------------------------------
  // transfer acknowledges while the processor holds busy
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      beats_r    <= CNT_RST;
      beats_go_r <= 1'b0;
    end else if (!bus.data_busy && !beats_go_r && beats_r == CNT_RST) begin
      beats_r    <= bus.burst ? BURST_BEATS_W : SINGLE_BEATS_W;
      beats_go_r <= 1'b1;
    end else if (beats_go_r) begin
      if (bus.data_busy || beats_r == 3'h1) begin              // [RL11]
        beats_go_r <= 1'b0;
        beats_r    <= CNT_RST;
      end else begin
        beats_r <= beats_r - 3'h1;
      end
    end
  end
  assign bus.transfer_ack = beats_go_r && !bus.data_busy;      // [RL22]
  assign bus.data_retry   = 1'b0;

  // ----------------------------------------------------------------
  // snooper: assert in the clock after acknowledge
  // ----------------------------------------------------------------
  assign snoop_fire    = address_acknowledge_r && (snoop_retry_req || snoop_shared_req); // [RL8] [RL9]
  // lone snooper never requests the bus, nothing to favour [RL7]
  assign snoop_pending = addr_open_r;

  btr_snoop_drv u_retry_drv (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .fire         (address_acknowledge_r && snoop_retry_req),
    .no_precharge (hw_impl_config_reg),
    .line_o       (bus.retry_o),
    .line_oe      (bus.retry_oe)
  );

  btr_snoop_drv u_shared_drv (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .fire         (snoop_fire && snoop_shared_req),
    .no_precharge (hw_impl_config_reg),
    .line_o       (bus.shared_o),
    .line_oe      (bus.shared_oe)
  );

endmodule : btr_sys_end

// File: test/btr_bus_props.sv
// checker: wire-level tenure, snoop and data busy properties
module btr_bus_props
  import btr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic transfer_start,
  input wire logic address_only_type_bit,
  input wire logic burst,
  input wire logic bus_request,
  input wire logic address_acknowledge,
  input wire logic data_grant,
  input wire logic data_retry,
  input wire logic transfer_ack,
  input wire logic retry_o,
  input wire logic retry_oe,
  input wire logic shared_o,
  input wire logic shared_oe,
  input wire logic addr_retry_response,
  input wire logic data_busy
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic       open_r;
  logic [2:0] acks_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // address phase open from start to acknowledge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) open_r <= 1'b0;
    else if (transfer_start) open_r <= 1'b1;
    else if (address_acknowledge) open_r <= 1'b0;
  end

  // beats acknowledged while busy is held
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) acks_r <= CNT_RST;
    else if (data_busy) acks_r <= CNT_RST;
    else if (transfer_ack) acks_r <= acks_r + 3'h1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_ACK_ONE: assert property (address_acknowledge |=> !address_acknowledge) else $error("ack too long");
  AST_ACK_IN_TENURE: assert property (address_acknowledge |-> open_r) else $error("ack outside tenure");
  AST_TS_SPACING: assert property (transfer_start |=> !transfer_start [*2]) else $error("tenure too short");
  AST_RETRY_BACKOFF: assert property (address_acknowledge ##1 !addr_retry_response |=>
    !bus_request ##[1:6] bus_request) else $error("no backoff or re-request");
  AST_QUALIFIED_DATA_GRANT_BUSY: assert property (data_grant && data_busy && !data_retry && addr_retry_response
    |=> !data_busy) else $error("busy missing after grant");
  AST_BUSY_CAUSE: assert property ($fell(data_busy) |-> $past(data_grant)) else $error("busy without grant");
  AST_BUSY_DROP: assert property (!data_busy && transfer_ack &&
    (acks_r + 3'h1 == (burst ? BURST_BEATS_W : SINGLE_BEATS_W)) |=> data_busy) else $error("busy kept");
  AST_RETRY_ABORT: assert property (address_acknowledge ##1 (!addr_retry_response && !data_busy)
    |-> ##[0:1] data_busy) else $error("busy not aborted");
  AST_WINDOW_GRANT: assert property (address_acknowledge ##1 (data_grant && !addr_retry_response && data_busy)
    |=> data_busy) else $error("owned bus on retry");
  AST_TA_AFTER_ACK: assert property (transfer_ack |-> !open_r || address_acknowledge) else $error("early ta");
  AST_NO_AO_GRANT: assert property (data_grant |-> !address_only_type_bit) else $error("grant addr only");
  AST_RETRY_RELEASE: assert property (retry_oe && !retry_o |=> !retry_oe ##1 (!retry_oe || retry_o))
    else $error("retry line release");
  AST_SHD_RELEASE: assert property (shared_oe && !shared_o |=> !shared_oe ##1 (!shared_oe || shared_o))
    else $error("shared line release");
endmodule : btr_bus_props

// File: test/bus_tenure_retry_arbitration_test.sv
// testbench: processor end and system end joined back to back
module bus_tenure_retry_arbitration_test import btr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       ref_clk, arst_n, req_valid, req_addr_only, req_burst, req_invalidate;
  logic       req_ready, tenure_done, tenure_retried, data_active, snoop_pending;
  logic       snoop_retry_req, snoop_shared_req, hw_impl_config_reg;
  logic [1:0] address_acknowledge_delay;
  btr_coh_t   fill_state, fs;
  btr_snoop_t snoop_decode, dec;
  int         n_mismatch, checks, cyc, nreq, nta, len, sp;
  logic       rtd, pre;

  btr_bus_if bus ();
  btr_proc_end i_btr_proc_end (.bus(bus), .ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_addr_only(req_addr_only), .req_burst(req_burst), .req_invalidate(req_invalidate),
    .req_ready(req_ready), .tenure_done(tenure_done), .tenure_retried(tenure_retried),
    .fill_state(fill_state), .snoop_decode(snoop_decode), .data_active(data_active));
  btr_sys_end i_btr_sys_end (.bus(bus), .ref_clk(ref_clk), .arst_n(arst_n), .snoop_retry_req(snoop_retry_req),
    .snoop_shared_req(snoop_shared_req), .hw_impl_config_reg(hw_impl_config_reg),
    .address_acknowledge_delay(address_acknowledge_delay), .snoop_pending(snoop_pending));
  btr_bus_props i_btr_bus_props (.ref_clk(ref_clk), .arst_n(arst_n), .transfer_start(bus.transfer_start),
    .address_only_type_bit(bus.address_only_type_bit), .burst(bus.burst), .bus_request(bus.bus_request),
    .address_acknowledge(bus.address_acknowledge), .data_grant(bus.data_grant), .data_retry(bus.data_retry),
    .transfer_ack(bus.transfer_ack), .retry_o(bus.retry_o), .retry_oe(bus.retry_oe), .shared_o(bus.shared_o),
    .shared_oe(bus.shared_oe), .addr_retry_response(bus.addr_retry_response), .data_busy(bus.data_busy));

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic run(input logic ao, bu, iv, rt, sh, input logic [1:0] dl);
    int   n;
    int   ts_at;
    logic done;
    @(negedge ref_clk);
    req_addr_only = ao;
    req_burst = bu;
    req_invalidate = iv;
    snoop_retry_req = rt;
    snoop_shared_req = sh;
    address_acknowledge_delay = dl;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    {nreq, nta, len, rtd, done, ts_at, sp, pre} = '0;
    for (n = 0; n < 80 && !(done && data_active === 1'b0); n++) begin
      if (bus.bus_request === 1'b1) nreq++;
      if (bus.transfer_start === 1'b1) ts_at = n;
      if (bus.transfer_ack === 1'b1) nta++;
      if (snoop_pending === 1'b1) sp++;
      if (bus.shared_oe === 1'b1 && bus.shared_o === 1'b1) pre = 1'b1;
      if (tenure_retried === 1'b1) begin
        rtd = 1'b1;
        dec = snoop_decode;
        nta = 0;
        snoop_retry_req = 1'b0;
        snoop_shared_req = 1'b0;
      end
      if (tenure_done === 1'b1) begin
        done = 1'b1;
        len = n - ts_at;
        fs = fill_state;
        if (!rtd) dec = snoop_decode;
      end
      @(negedge ref_clk);
    end
    chk(done, "tenure never ended");
    chk(len >= MIN_ADDR_TENURE_CLKS && len > dl, "tenure length");
  endtask : run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(req_ready === 1'b1 && data_active === 1'b0, "idle after reset");
    chk(bus.data_busy === 1'b1 && bus.addr_retry_response === 1'b1, "lines released");
  endtask : t_reset

  task automatic t_single();
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
    chk(nta == 1 && nreq == 1, "single beat count");
    chk(fs === BTR_COH_EXCLUSIVE && dec === BTR_SNP_CLEAN, "clean fill");
    chk(sp == 1, "acknowledge wait");
  endtask : t_single

  task automatic t_burst();
    run(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    chk(nta == BURST_BEATS, "burst beats");
    chk(sp == 3, "acknowledge wait");
  endtask : t_burst

  task automatic t_addr_only();
    run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
    chk(nta == 0, "address only got data");
  endtask : t_addr_only

  task automatic t_decode();
    btr_snoop_t exp_d;
    for (int i = 0; i < 4; i++) begin
      exp_d = (i == 0) ? BTR_SNP_CLEAN : (i == 1) ? BTR_SNP_BUSY_RETRY :
              (i == 2) ? BTR_SNP_SHARED_HIT : BTR_SNP_MODIFIED_HIT;
      run(1'b0, 1'b0, 1'b0, i[0], i[1], 2'h1);
      chk(dec === exp_d, "snoop decode");
      chk(rtd === i[0] && nreq == 1 + i[0], "retry and re-request");
      chk(fs === ((i == 2) ? BTR_COH_SHARED : BTR_COH_EXCLUSIVE), "fill state");
      chk(i != 2 || pre === 1'b1, "precharge missing");
    end
  endtask : t_decode

  task automatic t_inval();
    run(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2);
    chk(fs === BTR_COH_EXCLUSIVE && dec === BTR_SNP_SHARED_HIT, "invalidate fill");
  endtask : t_inval

  task automatic t_retry_burst();
    run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1);
    chk(rtd === 1'b1 && nta == BURST_BEATS, "retried burst repeated");
  endtask : t_retry_burst

  task automatic t_no_pre();
    hw_impl_config_reg = 1'b1;
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1);
    chk(fs === BTR_COH_SHARED && bus.snoop_shared_response === 1'b1 && pre === 1'b0, "no precharge shared");
    hw_impl_config_reg = 1'b0;
  endtask : t_no_pre

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, req_valid, req_addr_only, req_burst, req_invalidate} = '0;
    {snoop_retry_req, snoop_shared_req, hw_impl_config_reg} = '0;
    address_acknowledge_delay = 2'h1;
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_single();
    t_burst();
    t_addr_only();
    t_decode();
    t_inval();
    t_retry_burst();
    t_no_pre();
    results();
  end
endmodule : bus_tenure_retry_arbitration_test
